// >>> hdl/sfic_ctrl.sv
// Overview of operation
// - Width field picks 6, 7, 8, 10, 12 or 14 bit samples; 110, 111 reserved.
// - With buffer enabled, width code 101 yields twelve-bit samples.
// - Full-scale field decodes 2, 4, 8, 16, 12 g; codes 101-111 reserved.
// - Axis results are sign-extended two's complement at addresses 02h to 07h.
// - Stop bit clear: keep storing samples while space remains.
// - Stop bit set: drop samples once count reaches a nonzero level mark.
// - Buffer events, mark and mode act only when buffer enable is set.
// - Disabled buffer: samples go to results; enabled: samples go into buffer.
// - Status register shows buffer default flags while buffer is disabled.
// - Clear bit asynchronously empties pointers and zeroes buffer contents.
// - Drive bit selects open-drain (0) or push-pull (1) request pin.
// - Polarity bit selects active-low (0) or active-high (1) request.
// - Wake enable raises request on sniff-to-continuous-wake transition.
// - New-sample enable raises request when a sample is written.
// - Empty enable raises request only when stored count is zero.
// - Full enable raises request only when stored count is 32.
// - Level enable raises request when stored count reaches a nonzero mark.
// - Split enable raises request on sniff activity in split-wake mode only.
`timescale 1ns/1ps
module sfic_ctrl
    import sfic_pkg::*;
#(
    parameter int DEPTH = SFIC_DEPTH
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sample_valid_i,
    input wire logic [SFIC_RAW_W-1:0] sample_x_i,
    input wire logic [SFIC_RAW_W-1:0] sample_y_i,
    input wire logic [SFIC_RAW_W-1:0] sample_z_i,
    input wire logic continuous_wake_entry_i,
    input wire logic sniff_activity_i,
    input wire logic split_wake_mode_i,
    output logic [4:0] sample_bits_o,
    output logic [4:0] full_scale_g_o,
    output logic irq_pin_n_o,
    output logic irq_pin_n_oe_n_o
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam int EW = 3 * SFIC_ENTRY_W;

    logic [7:0] range_q, range_d, bctl_q, bctl_d, ictl_q, ictl_d;
    logic [SFIC_RES_W-1:0] res_q [3];
    logic [SFIC_RES_W-1:0] res_d [3];
    logic [SFIC_RES_W-1:0] trunc [3];
    logic [SFIC_RES_W-1:0] head [3];
    logic [SFIC_RAW_W-1:0] raw [3];
    logic [EW-1:0] buf_wdata, buf_rdata;
    logic [CW-1:0] count;
    logic [2:0] sample_width_sel;
    logic [4:0] buffer_level_mark;
    logic buf_en, stop_mode, buf_rstn, push, pop, written;
    logic empty, full, level_hit, irq_push_pull, irq_polarity_high;
    logic irq_en_new_sample, irq_en_buffer_level, irq_en_split_activity;
    logic new_q, new_d, wake_q, wake_d, split_q, split_d, st_rd, irq_any;
    logic [3:0] shift;
    logic [4:0] bits_d, bits_q, fs_d, fs_q;
    logic [7:0] rdata_d, rdata_q, status;
    logic pin_d, pin_q, oe_n_d, oe_n_q;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    assign sample_width_sel = range_q[SFIC_WSEL_LSB +: 3];
    assign buffer_level_mark = bctl_q[SFIC_MARK_LSB +: 5];
    assign buf_en = bctl_q[SFIC_BUF_EN];
    assign stop_mode = buf_en && bctl_q[SFIC_BUF_STOP];
    assign irq_push_pull = ictl_q[SFIC_IRQ_PP];
    assign irq_polarity_high = ictl_q[SFIC_IRQ_POL];
    assign irq_en_new_sample = ictl_q[SFIC_IRQ_NEW];
    assign irq_en_buffer_level = ictl_q[SFIC_IRQ_LEVEL];
    assign irq_en_split_activity = ictl_q[SFIC_IRQ_SPLIT];
    assign buf_rstn = rstn_i && !bctl_q[SFIC_BUF_CLR];
    assign raw[0] = sample_x_i;
    assign raw[1] = sample_y_i;
    assign raw[2] = sample_z_i;

    // ------------------------------------------------------------
    // Width and range decode
    // ------------------------------------------------------------
    always_comb
    begin
        case (sample_width_sel)
            SFIC_WC6: begin shift = SFIC_SH6; bits_d = SFIC_B6; end
            SFIC_WC7: begin shift = SFIC_SH7; bits_d = SFIC_B7; end
            SFIC_WC8: begin shift = SFIC_SH8; bits_d = SFIC_B8; end
            SFIC_WC10: begin shift = SFIC_SH10; bits_d = SFIC_B10; end
            SFIC_WC12: begin shift = SFIC_SH12; bits_d = SFIC_B12; end
            SFIC_WC14:
            begin
                shift = buf_en ? SFIC_SH12 : SFIC_SH14;
                bits_d = buf_en ? SFIC_B12 : SFIC_B14;
            end
            default: begin shift = SFIC_SH6; bits_d = SFIC_B6; end
        endcase
        case (range_q[SFIC_FS_LSB +: 3])
            SFIC_FS2: fs_d = SFIC_G2;
            SFIC_FS4: fs_d = SFIC_G4;
            SFIC_FS8: fs_d = SFIC_G8;
            SFIC_FS16: fs_d = SFIC_G16;
            SFIC_FS12: fs_d = SFIC_G12;
            default: fs_d = SFIC_G_NONE;
        endcase
    end

    // ------------------------------------------------------------
    // Sample formatting and buffer path
    // ------------------------------------------------------------
    for (genvar a = 0; a < 3; a++)
    begin : g_axis
        logic signed [SFIC_RAW_W-1:0] sh;
        assign sh = $signed(raw[a]) >>> shift;
        assign trunc[a] = {{(SFIC_RES_W-SFIC_RAW_W){sh[SFIC_RAW_W-1]}}, sh};
        assign buf_wdata[a*SFIC_ENTRY_W +: SFIC_ENTRY_W] = sh[SFIC_ENTRY_W-1:0];
        assign head[a] = {{(SFIC_RES_W-SFIC_ENTRY_W)
            {buf_rdata[a*SFIC_ENTRY_W+SFIC_ENTRY_W-1]}},
            buf_rdata[a*SFIC_ENTRY_W +: SFIC_ENTRY_W]};
    end

    assign empty = (count == '0);
    assign full = (count == CW'(DEPTH));
    assign level_hit = (buffer_level_mark != '0) && (count >= CW'(buffer_level_mark));
    assign push = buf_en && sample_valid_i && !full && !(stop_mode && level_hit);
    assign pop = buf_en && reg_rd_i && (reg_addr_i == SFIC_ADDR_ZH);
    assign written = push || (!buf_en && sample_valid_i);

    sfic_sample_buf #(
        .WIDTH(EW),
        .DEPTH(DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .rstn_i(buf_rstn),
        .push_i(push),
        .pop_i(pop),
        .wdata_i(buf_wdata),
        .rdata_o(buf_rdata),
        .count_o(count)
    );

    // ------------------------------------------------------------
    // Registers, results and sticky events
    // ------------------------------------------------------------
    assign st_rd = reg_rd_i && (reg_addr_i == SFIC_ADDR_STATUS);

    always_comb
    begin
        range_d = range_q;
        bctl_d = bctl_q;
        ictl_d = ictl_q;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                SFIC_ADDR_RANGE: range_d = reg_wdata_i & SFIC_RANGE_MASK;
                SFIC_ADDR_BUF: bctl_d = reg_wdata_i;
                SFIC_ADDR_IRQ: ictl_d = reg_wdata_i;
                default: ;
            endcase
        end
        for (int i = 0; i < 3; i++)
            res_d[i] = (!buf_en && sample_valid_i) ? trunc[i] : res_q[i];
        new_d = written || (new_q && !st_rd);
        wake_d = continuous_wake_entry_i || (wake_q && !st_rd);
        split_d = (sniff_activity_i && split_wake_mode_i) || (split_q && !st_rd);
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            range_q <= SFIC_RANGE_RST;
            bctl_q <= SFIC_BUF_RST;
            ictl_q <= SFIC_IRQ_RST;
            for (int i = 0; i < 3; i++)
                res_q[i] <= '0;
            new_q <= 1'b0;
            wake_q <= 1'b0;
            split_q <= 1'b0;
        end
        else
        begin
            range_q <= range_d;
            bctl_q <= bctl_d;
            ictl_q <= ictl_d;
            res_q <= res_d;
            new_q <= new_d;
            wake_q <= wake_d;
            split_q <= split_d;
        end
    end

    // ------------------------------------------------------------
    // Read data, request pin and decoded outputs
    // ------------------------------------------------------------
    always_comb
    begin
        status = '0;
        status[SFIC_ST_EMPTY] = buf_en ? empty : 1'b1;
        status[SFIC_ST_FULL] = buf_en && full;
        status[SFIC_ST_LEVEL] = buf_en && level_hit;
        status[SFIC_ST_NEW] = new_q;
        status[SFIC_ST_WAKE] = wake_q;
        status[SFIC_ST_SPLIT] = split_q;
        rdata_d = rdata_q;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                SFIC_ADDR_XL: rdata_d = buf_en ? head[0][7:0] : res_q[0][7:0];
                SFIC_ADDR_XH: rdata_d = buf_en ? head[0][15:8] : res_q[0][15:8];
                SFIC_ADDR_YL: rdata_d = buf_en ? head[1][7:0] : res_q[1][7:0];
                SFIC_ADDR_YH: rdata_d = buf_en ? head[1][15:8] : res_q[1][15:8];
                SFIC_ADDR_ZL: rdata_d = buf_en ? head[2][7:0] : res_q[2][7:0];
                SFIC_ADDR_ZH: rdata_d = buf_en ? head[2][15:8] : res_q[2][15:8];
                SFIC_ADDR_STATUS: rdata_d = status;
                SFIC_ADDR_RANGE: rdata_d = range_q;
                SFIC_ADDR_BUF: rdata_d = bctl_q;
                SFIC_ADDR_IRQ: rdata_d = ictl_q;
                default: rdata_d = '0;
            endcase
        end
        irq_any = (irq_en_new_sample && new_q)
            || (ictl_q[SFIC_IRQ_WAKE] && wake_q)
            || (irq_en_split_activity && split_q)
            || (buf_en && ictl_q[SFIC_IRQ_EMPTY] && empty)
            || (buf_en && ictl_q[SFIC_IRQ_FULL] && full)
            || (buf_en && irq_en_buffer_level && level_hit);
        pin_d = irq_polarity_high ? irq_any : !irq_any;
        oe_n_d = irq_push_pull ? 1'b0 : pin_d;
        if (!irq_push_pull)
            pin_d = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_q <= '0;
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
            bits_q <= SFIC_B6;
            fs_q <= SFIC_G2;
        end
        else
        begin
            rdata_q <= rdata_d;
            pin_q <= pin_d;
            oe_n_q <= oe_n_d;
            bits_q <= bits_d;
            fs_q <= fs_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign irq_pin_n_o = pin_q;
    assign irq_pin_n_oe_n_o = oe_n_q;
    assign sample_bits_o = bits_q;
    assign full_scale_g_o = fs_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_width_eight:
        assert property (sample_valid_i && !buf_en && sample_width_sel == SFIC_WC8
            |=> res_q[0] == {{8{$past(sample_x_i[13])}}, $past(sample_x_i[13:6])})
        else $error("eight-bit result wrong");
    a_buf_twelve:
        assert property (buf_en && sample_width_sel == SFIC_WC14 |=> sample_bits_o == SFIC_B12)
        else $error("buffered fourteen-bit code not twelve bits");
    a_range_code:
        assert property (range_q[SFIC_FS_LSB +: 3] == SFIC_FS12 |=> full_scale_g_o == SFIC_G12)
        else $error("range decode wrong");
    a_sign_extend:
        assert property (sample_valid_i && !buf_en && sample_width_sel == SFIC_WC14
            |=> res_q[1] == {{2{$past(sample_y_i[13])}}, $past(sample_y_i)})
        else $error("result not sign extended");
    a_keep_writing:
        assert property (buf_en && !bctl_q[SFIC_BUF_STOP] && sample_valid_i && !full && !pop
            && !bctl_q[SFIC_BUF_CLR] && !$past(bctl_q[SFIC_BUF_CLR])
            |=> count == $past(count) + 1'b1 || bctl_q[SFIC_BUF_CLR])
        else $error("sample not stored");
    a_mark_drop:
        assert property (stop_mode && level_hit && sample_valid_i && !pop
            |=> count == $past(count) || bctl_q[SFIC_BUF_CLR])
        else $error("sample stored past level mark");
    a_clear_empty:
        assert property (bctl_q[SFIC_BUF_CLR] |-> count == '0)
        else $error("buffer not cleared");
    a_od_never_high:
        assert property (!irq_push_pull |=> !irq_pin_n_o)
        else $error("open drain pin driven high");
    a_pin_level:
        assert property (irq_push_pull && irq_any
            |=> irq_pin_n_o == $past(irq_polarity_high) && !irq_pin_n_oe_n_o)
        else $error("request level wrong");
    a_new_flag:
        assert property (written |=> new_q ##1 (new_q || $past(st_rd)))
        else $error("new sample flag missing");
    a_empty_irq:
        assert property (buf_en && ictl_q[SFIC_IRQ_EMPTY] && empty |-> irq_any)
        else $error("empty request missing");
    a_full_irq:
        assert property (ictl_q[SFIC_IRQ_FULL] && irq_any && !ictl_q[SFIC_IRQ_NEW]
            && !ictl_q[SFIC_IRQ_WAKE] && !ictl_q[SFIC_IRQ_SPLIT] && !ictl_q[SFIC_IRQ_EMPTY]
            && !ictl_q[SFIC_IRQ_LEVEL] |-> buf_en && count == CW'(DEPTH))
        else $error("full request at wrong count");
    a_split_gate:
        assert property (sniff_activity_i && !split_wake_mode_i && !split_q |=> !split_q)
        else $error("split event outside split-wake mode");

    c_buf_full: cover property (buf_en && full);
    c_mark_drop: cover property (stop_mode && level_hit && sample_valid_i);
    c_pop_read: cover property (pop && !empty ##2 reg_rd_i);
    c_irq_push_pull: cover property (irq_push_pull && irq_any ##1 irq_pin_n_o);
endmodule

// >>> hdl/sfic_pkg.sv
package sfic_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] SFIC_ADDR_XL = 8'h02;
    localparam logic [7:0] SFIC_ADDR_XH = 8'h03;
    localparam logic [7:0] SFIC_ADDR_YL = 8'h04;
    localparam logic [7:0] SFIC_ADDR_YH = 8'h05;
    localparam logic [7:0] SFIC_ADDR_ZL = 8'h06;
    localparam logic [7:0] SFIC_ADDR_ZH = 8'h07;
    localparam logic [7:0] SFIC_ADDR_STATUS = 8'h08;
    localparam logic [7:0] SFIC_ADDR_RANGE = 8'h15;
    localparam logic [7:0] SFIC_ADDR_BUF = 8'h16;
    localparam logic [7:0] SFIC_ADDR_IRQ = 8'h17;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] SFIC_RANGE_RST = 8'h00;
    localparam logic [7:0] SFIC_BUF_RST = 8'h00;
    localparam logic [7:0] SFIC_IRQ_RST = 8'h00;
    localparam logic [7:0] SFIC_RANGE_MASK = 8'h77;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SFIC_WSEL_LSB = 0;
    localparam int SFIC_FS_LSB = 4;
    localparam int SFIC_MARK_LSB = 0;
    localparam int SFIC_BUF_STOP = 5;
    localparam int SFIC_BUF_EN = 6;
    localparam int SFIC_BUF_CLR = 7;
    localparam int SFIC_IRQ_PP = 0;
    localparam int SFIC_IRQ_POL = 1;
    localparam int SFIC_IRQ_WAKE = 2;
    localparam int SFIC_IRQ_NEW = 3;
    localparam int SFIC_IRQ_EMPTY = 4;
    localparam int SFIC_IRQ_FULL = 5;
    localparam int SFIC_IRQ_LEVEL = 6;
    localparam int SFIC_IRQ_SPLIT = 7;
    localparam int SFIC_ST_EMPTY = 0;
    localparam int SFIC_ST_FULL = 1;
    localparam int SFIC_ST_LEVEL = 2;
    localparam int SFIC_ST_NEW = 3;
    localparam int SFIC_ST_WAKE = 4;
    localparam int SFIC_ST_SPLIT = 5;

    // ------------------------------------------------------------
    // Widths, width codes and range codes
    // ------------------------------------------------------------
    localparam int SFIC_RAW_W = 14;
    localparam int SFIC_RES_W = 16;
    localparam int SFIC_ENTRY_W = 12;
    localparam int SFIC_DEPTH = 32;
    localparam logic [2:0] SFIC_WC6 = 3'h0;
    localparam logic [2:0] SFIC_WC7 = 3'h1;
    localparam logic [2:0] SFIC_WC8 = 3'h2;
    localparam logic [2:0] SFIC_WC10 = 3'h3;
    localparam logic [2:0] SFIC_WC12 = 3'h4;
    localparam logic [2:0] SFIC_WC14 = 3'h5;
    localparam logic [3:0] SFIC_SH6 = 4'h8;
    localparam logic [3:0] SFIC_SH7 = 4'h7;
    localparam logic [3:0] SFIC_SH8 = 4'h6;
    localparam logic [3:0] SFIC_SH10 = 4'h4;
    localparam logic [3:0] SFIC_SH12 = 4'h2;
    localparam logic [3:0] SFIC_SH14 = 4'h0;
    localparam logic [4:0] SFIC_B6 = 5'h06;
    localparam logic [4:0] SFIC_B7 = 5'h07;
    localparam logic [4:0] SFIC_B8 = 5'h08;
    localparam logic [4:0] SFIC_B10 = 5'h0A;
    localparam logic [4:0] SFIC_B12 = 5'h0C;
    localparam logic [4:0] SFIC_B14 = 5'h0E;
    localparam logic [2:0] SFIC_FS2 = 3'h0;
    localparam logic [2:0] SFIC_FS4 = 3'h1;
    localparam logic [2:0] SFIC_FS8 = 3'h2;
    localparam logic [2:0] SFIC_FS16 = 3'h3;
    localparam logic [2:0] SFIC_FS12 = 3'h4;
    localparam logic [4:0] SFIC_G2 = 5'h02;
    localparam logic [4:0] SFIC_G4 = 5'h04;
    localparam logic [4:0] SFIC_G8 = 5'h08;
    localparam logic [4:0] SFIC_G16 = 5'h10;
    localparam logic [4:0] SFIC_G12 = 5'h0C;
    localparam logic [4:0] SFIC_G_NONE = 5'h00;

endpackage

// >>> hdl/sfic_sample_buf.sv
`timescale 1ns/1ps
module sfic_sample_buf #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic do_push, do_pop;

    // ------------------------------------------------------------
    // Pointers and count
    // ------------------------------------------------------------
    always_comb
    begin
        do_push = push_i && (cnt_q != (AW+1)'(DEPTH));
        do_pop = pop_i && (cnt_q != '0);
        wr_d = do_push ? wr_q + 1'b1 : wr_q;
        rd_d = do_pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Storage, zeroed by the buffer reset
    // ------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        logic [WIDTH-1:0] ent_d;
        always_comb
        begin
            ent_d = (do_push && wr_q == AW'(i)) ? wdata_i : mem_q[i];
        end
        always_ff @(posedge clk_i or negedge rstn_i)
        begin
            if (!rstn_i)
                mem_q[i] <= '0;
            else
                mem_q[i] <= ent_d;
        end
    end

    assign rdata_o = mem_q[rd_q];
    assign count_o = cnt_q;
endmodule

// >>> testbench/sfic_host_pin.sv
`timescale 1ns/1ps
// ------------------------------
// Host view of request pin
// ------------------------------
module sfic_host_pin (
    input wire logic irq_pin_n_i,
    input wire logic irq_oe_n_i,
    output logic pin_level_o
);
    // Released pin floats to the pull-up level
    assign pin_level_o = irq_oe_n_i ? 1'b1 : irq_pin_n_i;
endmodule

// >>> testbench/test_sfic_ctrl.sv
`timescale 1ns/1ps
module test_sfic_ctrl
    import sfic_pkg::*;
;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic sample_valid_i = 1'b0;
    logic [13:0] smp_x = 14'h0000;
    logic continuous_wake_entry_i = 1'b0;
    logic sniff_activity_i = 1'b0;
    logic split_wake_mode_i = 1'b0;
    logic [4:0] sample_bits_o;
    logic [4:0] full_scale_g_o;
    logic irq_pin_n_o;
    logic irq_pin_n_oe_n_o;
    logic pin_level;
    int err_total = 0;
    int compares = 0;

    always #10 clk_i = ~clk_i;

    sfic_ctrl i_sfic_ctrl (
        .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .sample_valid_i(sample_valid_i), .sample_x_i(smp_x), .sample_y_i(smp_x),
        .sample_z_i(smp_x), .continuous_wake_entry_i(continuous_wake_entry_i),
        .sniff_activity_i(sniff_activity_i), .split_wake_mode_i(split_wake_mode_i),
        .sample_bits_o(sample_bits_o), .full_scale_g_o(full_scale_g_o),
        .irq_pin_n_o(irq_pin_n_o), .irq_pin_n_oe_n_o(irq_pin_n_oe_n_o)
    );
    sfic_host_pin i_sfic_host_pin (
        .irq_pin_n_i(irq_pin_n_o), .irq_oe_n_i(irq_pin_n_oe_n_o), .pin_level_o(pin_level)
    );

    // ------------------------------
    // Bus and check tasks
    // ------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
        tick(1);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick(1);
        reg_rd_i = 1'b0;
        if (name != "")
            chk(name, e, reg_rdata_o);
    endtask
    task automatic smp(input logic [13:0] x);
        tick(1);
        smp_x = x;
        sample_valid_i = 1'b1;
        tick(1);
        sample_valid_i = 1'b0;
    endtask
    task automatic pin(input logic e);
        tick(2);
        chk("pin", {7'h00, e}, {7'h00, pin_level});
    endtask
    task automatic summarize();
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_reset();
        rd(SFIC_ADDR_RANGE, SFIC_RANGE_RST, "range");
        rd(SFIC_ADDR_BUF, SFIC_BUF_RST, "buf");
        rd(SFIC_ADDR_IRQ, SFIC_IRQ_RST, "irq");
        rd(8'h3F, 8'h00, "unmapped");
        rd(SFIC_ADDR_STATUS, 8'h01, "status");
        pin(1'b1);
    endtask
    task automatic t_width();
        logic [4:0] eb[8] = '{SFIC_B6, SFIC_B7, SFIC_B8, SFIC_B10, SFIC_B12, SFIC_B14,
            SFIC_B6, SFIC_B6};
        logic [4:0] eg[8] = '{SFIC_G2, SFIC_G4, SFIC_G8, SFIC_G16, SFIC_G12, SFIC_G_NONE,
            SFIC_G_NONE, SFIC_G_NONE};
        for (int i = 0; i < 8; i++)
        begin
            wr(SFIC_ADDR_RANGE, {1'b0, i[2:0], 1'b0, i[2:0]});
            tick(1);
            chk("bits", {3'h0, eb[i]}, {3'h0, sample_bits_o});
            chk("scale", {3'h0, eg[i]}, {3'h0, full_scale_g_o});
        end
        wr(SFIC_ADDR_RANGE, 8'hFF);
        rd(SFIC_ADDR_RANGE, 8'h77, "range");
    endtask
    task automatic t_direct();
        wr(SFIC_ADDR_RANGE, 8'h05);
        smp(14'h2001);
        rd(SFIC_ADDR_XL, 8'h01, "xl");
        rd(SFIC_ADDR_XH, 8'hE0, "xh");
        wr(SFIC_ADDR_RANGE, 8'h02);
        smp(14'h2001);
        wr(SFIC_ADDR_XL, 8'h55);
        rd(SFIC_ADDR_XL, 8'h80, "xl8");
        rd(SFIC_ADDR_ZH, 8'hFF, "zh8");
        rd(SFIC_ADDR_STATUS, 8'h09, "status");
    endtask
    task automatic t_order();
        wr(SFIC_ADDR_RANGE, 8'h05);
        wr(SFIC_ADDR_BUF, 8'h40);
        tick(1);
        chk("bits", 8'h0C, {3'h0, sample_bits_o});
        for (int k = 1; k < 4; k++)
            smp(14'(16 * k));
        for (int k = 1; k < 4; k++)
        begin
            rd(SFIC_ADDR_XL, 8'(4 * k), "fifo");
            rd(SFIC_ADDR_ZH, 8'h00, "fifo");
        end
        rd(SFIC_ADDR_STATUS, 8'h09, "status");
    endtask
    task automatic t_fill();
        wr(SFIC_ADDR_IRQ, 8'h20);
        pin(1'b1);
        for (int k = 0; k < 33; k++)
            smp(14'h0100);
        pin(1'b0);
        rd(SFIC_ADDR_STATUS, 8'h0A, "status");
        wr(SFIC_ADDR_IRQ, 8'h10);
        wr(SFIC_ADDR_BUF, 8'hC0);
        wr(SFIC_ADDR_BUF, 8'h40);
        rd(SFIC_ADDR_STATUS, 8'h01, "status");
        pin(1'b0);
        wr(SFIC_ADDR_BUF, 8'h00);
        pin(1'b1);
    endtask
    task automatic t_stop();
        wr(SFIC_ADDR_BUF, 8'h63);
        wr(SFIC_ADDR_IRQ, 8'h40);
        for (int k = 0; k < 5; k++)
            smp(14'h0040);
        pin(1'b0);
        rd(SFIC_ADDR_STATUS, 8'h0C, "status");
        for (int k = 0; k < 3; k++)
            rd(SFIC_ADDR_ZH, 8'h00, "fifo");
        rd(SFIC_ADDR_STATUS, 8'h01, "status");
        pin(1'b1);
    endtask
    task automatic t_irq();
        wr(SFIC_ADDR_BUF, 8'h00);
        wr(SFIC_ADDR_IRQ, 8'h0B);
        smp(14'h0001);
        tick(2);
        chk("oe", 8'h00, {7'h00, irq_pin_n_oe_n_o});
        chk("out", 8'h01, {7'h00, irq_pin_n_o});
        rd(SFIC_ADDR_STATUS, 8'h09, "status");
        pin(1'b0);
        wr(SFIC_ADDR_IRQ, 8'h84);
        pin(1'b1);
        sniff_activity_i = 1'b1;
        tick(1);
        sniff_activity_i = 1'b0;
        pin(1'b1);
        continuous_wake_entry_i = 1'b1;
        tick(1);
        continuous_wake_entry_i = 1'b0;
        pin(1'b0);
        rd(SFIC_ADDR_STATUS, 8'h11, "status");
        pin(1'b1);
        split_wake_mode_i = 1'b1;
        sniff_activity_i = 1'b1;
        tick(1);
        sniff_activity_i = 1'b0;
        pin(1'b0);
    endtask

    // ------------------------------
    // Main sequence and watchdog
    // ------------------------------
    initial
    begin
        tick(16);
        rstn_i = 1'b1;
        t_reset();
        t_width();
        t_direct();
        t_order();
        t_fill();
        t_stop();
        t_irq();
        summarize();
    end
    initial
    begin
        #200000;
        err_total++;
        summarize();
    end
endmodule
